// ### rasp_device.sv
// Angle sensor end: serial slave on the link clock, PWM and timeout on the internal clock
//
// Added by the designer: the strobed register port and the address map.
`default_nettype none
module rasp_device
  import rasp_pkg::*;
(
  // Internal clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Serial link
  rasp_link_if.dev link,
  // Sensor core
  input wire logic [rasp_pkg::ANGLE_W-1:0] angle_in,
  input wire logic [rasp_pkg::AGC_W-1:0] agc_in,
  input wire logic lock_in,
  input wire logic angle_valid_in,
  input wire logic prog_voltage_ok_in,
  // Outputs
  output logic pwm_out,
  output logic [rasp_pkg::GAIN_W-1:0] gain_out,
  output logic low_power_out,
  output logic [rasp_pkg::OTP_W-1:0] otp_data_out
);
  localparam int CFG_W = OTP_W + GAIN_W + 1;

  // ---------------- Link clock domain ----------------
  logic tmo_pulse_q;
  logic frame_rst;
  logic [5:0] cnt_q;
  logic [CMD_W-1:0] cmd_q;
  logic rd_q;
  logic ext_q;
  logic [OTP_W-1:0] shift_q;
  logic act_tgl_q;
  logic [GAIN_W-1:0] gain_q;
  logic lp_q;
  logic [OTP_W-1:0] otp_q;
  logic dev_oe_q;
  logic dev_data_q;
  logic prog_ok_l;
  logic [ANGLE_W+AGC_W:0] snap_q;

  // Frame state clears on chip select low or on a timeout pulse; the pulse only
  // arrives after 20 us of clock silence, so its release never meets an edge.
  assign frame_rst = reset_in | ~link.cs | tmo_pulse_q;

  wire sd = link.serial_data_io;
  wire [CMD_W-1:0] cmd_d = {cmd_q[CMD_W-2:0], sd};
  wire ext_d = (cmd_d[CMD_W-2:0] == CMD_EXT_TAIL);
  wire in_cmd = (cnt_q <= CMD_LAST);
  wire in_data = (cnt_q >= DATA_FIRST) && (cnt_q != CNT_IDLE);
  wire [5:0] last_cnt = ext_q ? LAST_EXT : LAST_NORM;
  wire at_last = in_data && (cnt_q == last_cnt);
  wire [OTP_W-1:0] word_d = {shift_q[OTP_W-2:0], sd};

  // Read words built at the end of the command
  wire [DATA_W-2:0] angle_body = snap_q;
  wire [DATA_W-1:0] angle_word = {angle_body, ^angle_body};
  wire [DATA_W-1:0] cust_word = {{(DATA_W-GAIN_W-GAIN_LSB){1'b0}}, gain_q,
                                 {GAIN_LSB{1'b0}}};
  wire [DATA_W-1:0] norm_word = (cmd_d == CMD_RD_ANGLE) ? angle_word :
                                (cmd_d == CMD_RD_CUST) ? cust_word : '0;
  wire [OTP_W-1:0] load_word = (cmd_d == CMD_RD_OTP) ? otp_q :
                               {norm_word, {(OTP_W-DATA_W){1'b0}}};

  always_ff @(posedge link.sclk or posedge frame_rst) begin
    if (frame_rst) begin
      cnt_q <= '0;
      cmd_q <= '0;
      rd_q <= 1'b0;
      ext_q <= 1'b0;
      shift_q <= '0;
    end else if (cnt_q != CNT_IDLE) begin
      cnt_q <= at_last ? CNT_IDLE : cnt_q + 6'h01;
      if (in_cmd) begin
        cmd_q <= cmd_d;
      end
      if (cnt_q == CMD_LAST) begin
        rd_q <= ~cmd_d[CMD_W-1];
        ext_q <= ext_d;
        shift_q <= load_word;
      end else if (in_data) begin
        shift_q <= word_d;
      end
    end
  end

  // Configuration survives frames; only a completed write frame changes it
  always_ff @(posedge link.sclk or posedge reset_in) begin
    if (reset_in) begin
      act_tgl_q <= 1'b0;
      gain_q <= GAIN_RST;
      lp_q <= 1'b0;
      otp_q <= '0;
    end else begin
      act_tgl_q <= ~act_tgl_q;
      if (at_last && !rd_q) begin
        if (cmd_q == CMD_WR_CONFIG) begin
          lp_q <= word_d[SLEEP_BIT];
        end
        if (cmd_q == CMD_WR_CUST) begin
          gain_q <= word_d[GAIN_LSB +: GAIN_W];
        end
        // Fuses only ever blow, so programmed bits stay set
        if (cmd_q == CMD_WR_OTP && prog_ok_l) begin
          otp_q <= otp_q | word_d;
        end
      end
    end
  end

  // Drive on the falling edge: half a clock after the last command bit
  always_ff @(negedge link.sclk or posedge frame_rst) begin
    if (frame_rst) begin
      dev_oe_q <= 1'b0;
      dev_data_q <= 1'b0;
    end else begin
      dev_oe_q <= rd_q && in_data;
      dev_data_q <= shift_q[OTP_W-1];
    end
  end

  assign link.dev_data = dev_data_q;
  assign link.dev_oe = dev_oe_q;

  // Programming voltage is a slow static level; link clock only runs in frames
  rasp_sync #(.W(1)) u_prog_sync (
    .clk_in(link.sclk),
    .reset_in(reset_in),
    .d_in(prog_voltage_ok_in),
    .q_out(prog_ok_l)
  );

  // ---------------- Internal clock domain ----------------
  logic act_m;
  logic act_prev_q;
  logic cs_m;
  logic [8:0] tmo_cnt_q;
  logic [CFG_W-1:0] cfg_m;
  logic [$clog2(PWM_UNIT_CYC)-1:0] unit_cnt_q;
  logic [8:0] slot_q;
  logic [ANGLE_W-1:0] pos_q;
  logic valid_q;

  rasp_sync #(.W(1)) u_act_sync (
    .clk_in(mclk_in),
    .reset_in(reset_in),
    .d_in(act_tgl_q),
    .q_out(act_m)
  );

  rasp_sync #(.W(1)) u_cs_sync (
    .clk_in(mclk_in),
    .reset_in(reset_in),
    .d_in(link.cs),
    .q_out(cs_m)
  );

  // Configuration changes only at frame ends, so the word is quasi-static
  rasp_sync #(.W(CFG_W)) u_cfg_sync (
    .clk_in(mclk_in),
    .reset_in(reset_in),
    .d_in({lp_q, gain_q, otp_q}),
    .q_out(cfg_m)
  );

  // Timeout counter restarts on each rising link edge seen here
  wire act_seen = (act_m != act_prev_q);
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      act_prev_q <= 1'b0;
      tmo_cnt_q <= '0;
      tmo_pulse_q <= 1'b0;
    end else begin
      act_prev_q <= act_m;
      tmo_pulse_q <= !act_seen && (tmo_cnt_q == TO_CYC - 9'h001);
      if (act_seen) begin
        tmo_cnt_q <= '0;
      end else if (tmo_cnt_q != TO_CYC) begin
        tmo_cnt_q <= tmo_cnt_q + 9'h001;
      end
    end
  end

  // Snapshot held still while a frame runs so the link reads a stable word
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      snap_q <= '0;
    end else if (!cs_m) begin
      snap_q <= {lock_in & ~cfg_m[CFG_W-1], agc_in, angle_in};
    end
  end

  // PWM: 257 slots of one unit each
  wire unit_end = (unit_cnt_q == PWM_UNIT_CYC[$bits(unit_cnt_q)-1:0] - 1'b1);
  wire period_end = unit_end && (slot_q == PWM_SLOTS - 9'h001);
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      unit_cnt_q <= '0;
      slot_q <= '0;
      pos_q <= '0;
      valid_q <= 1'b0;
      pwm_out <= 1'b0;
    end else begin
      unit_cnt_q <= unit_end ? '0 : unit_cnt_q + 1'b1;
      if (period_end) begin
        slot_q <= '0;
        pos_q <= angle_in;
        valid_q <= angle_valid_in;
      end else if (unit_end) begin
        slot_q <= slot_q + 9'h001;
      end
      pwm_out <= valid_q && (slot_q <= {1'b0, pos_q});
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      low_power_out <= 1'b0;
      gain_out <= GAIN_RST;
      otp_data_out <= '0;
    end else begin
      low_power_out <= cfg_m[CFG_W-1];
      gain_out <= cfg_m[OTP_W +: GAIN_W];
      otp_data_out <= cfg_m[OTP_W-1:0];
    end
  end
endmodule // rasp_device
`default_nettype wire

// ### rasp_pkg.sv
// Shared constants and types for the rotary angle serial and PWM output block
`default_nettype none
package rasp_pkg;
  // Frame layout
  localparam int CMD_W = 5;
  localparam int DATA_W = 16;
  localparam int OTP_W = 46;
  localparam int FRAME_W = CMD_W + OTP_W;
  localparam int ANGLE_W = 8;
  localparam int AGC_W = 6;
  localparam int GAIN_W = 3;
  localparam logic [5:0] CMD_LAST = 6'(CMD_W - 1);
  localparam logic [5:0] DATA_FIRST = 6'(CMD_W);
  localparam logic [5:0] LAST_NORM = 6'(CMD_W + DATA_W - 1);
  localparam logic [5:0] LAST_EXT = 6'(CMD_W + OTP_W - 1);
  localparam logic [5:0] CNT_IDLE = 6'h3F;
  // Commands
  localparam logic [4:0] CMD_RD_ANGLE = 5'h00;
  localparam logic [4:0] CMD_RD_CUST = 5'h07;
  localparam logic [4:0] CMD_RD_OTP = 5'h0F;
  localparam logic [4:0] CMD_WR_CONFIG = 5'h11;
  localparam logic [4:0] CMD_WR_CUST = 5'h17;
  localparam logic [4:0] CMD_WR_OTP = 5'h1F;
  localparam logic [3:0] CMD_EXT_TAIL = 4'hF;
  // Field positions in the 16-bit data word
  localparam int SLEEP_BIT = 15;
  localparam int GAIN_LSB = 6;
  // Reset values
  localparam logic [GAIN_W-1:0] GAIN_RST = 3'h0;
  // Timing
  localparam int MCLK_MHZ = 20;
  localparam real PWM_UNIT_US = 0.556;
  localparam int PWM_UNIT_CYC = int'($floor(PWM_UNIT_US * MCLK_MHZ));
  localparam logic [8:0] PWM_SLOTS = 9'h101;
  localparam int TO_MIN_US = 20;
  localparam logic [8:0] TO_CYC = 9'(TO_MIN_US * MCLK_MHZ);
  localparam int SCLK_KHZ = 250;
  localparam logic [7:0] SCLK_HALF_CYC = 8'((MCLK_MHZ * 1000) / (2 * SCLK_KHZ));
  // Host register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_WLO = 8'h04;
  localparam logic [7:0] ADDR_WHI = 8'h08;
  localparam logic [7:0] ADDR_RLO = 8'h0C;
  localparam logic [7:0] ADDR_RHI = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  typedef enum {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_HOLD} rasp_host_state_t;
endpackage
`default_nettype wire

// ### rasp_link_if.sv
// Three-wire serial link between the controller and the angle sensor
`default_nettype none
interface rasp_link_if;
  logic cs;
  logic sclk;
  logic host_data;
  logic host_oe;
  logic dev_data;
  logic dev_oe;
  logic serial_data_io;
  // Resolved line level; an idle line is pulled high
  assign serial_data_io = dev_oe ? dev_data : (host_oe ? host_data : 1'b1);
  modport dev (input cs, input sclk, input serial_data_io, output dev_data, output dev_oe);
  modport host (output cs, output sclk, output host_data, output host_oe,
                input serial_data_io);
endinterface
`default_nettype wire

// ### rasp_sync.sv
// Three-stage synchroniser that passes a change once stages two and three agree
`default_nettype none
module rasp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Data
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q_out <= '0;
    end else begin
      s1_q <= d_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        q_out <= s3_q;
      end
    end
  end
endmodule // rasp_sync
`default_nettype wire

// ### rasp_host.sv
// Controller end: register port for software, serial master generating the link clock
`default_nettype none
module rasp_host
  import rasp_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // Serial link
  rasp_link_if.host link
);
  rasp_host_state_t state_q;
  logic [7:0] tick_q;
  logic [5:0] bit_q;
  logic [FRAME_W-1:0] tx_q;
  logic [OTP_W-1:0] rx_q;
  logic [OTP_W-1:0] rdat_q;
  logic [OTP_W-1:0] wdat_q;
  logic [CMD_W-1:0] cmd_q;
  logic done_q;
  logic cs_q;
  logic sclk_q;
  logic hdata_q;
  logic hoe_q;
  logic din_m;

  rasp_sync #(.W(1)) u_din_sync (
    .clk_in(mclk_in),
    .reset_in(reset_in),
    .d_in(link.serial_data_io),
    .q_out(din_m)
  );

  wire busy = (state_q != H_IDLE);
  wire start = wr_in && (addr_in == ADDR_CTRL) && !busy;
  wire rd_cmd = ~cmd_q[CMD_W-1];
  wire ext = (cmd_q[CMD_W-2:0] == CMD_EXT_TAIL);
  wire [5:0] last_bit = ext ? LAST_EXT : LAST_NORM;
  wire half_end = (tick_q == SCLK_HALF_CYC - 8'h01);
  wire in_data = (bit_q >= DATA_FIRST);
  wire [CMD_W-1:0] cmd_new = wdata_in[CMD_W-1:0];
  wire ext_new = (cmd_new[CMD_W-2:0] == CMD_EXT_TAIL);
  wire [FRAME_W-1:0] tx_new = ext_new ? {cmd_new, wdat_q} :
                              {cmd_new, wdat_q[DATA_W-1:0], {(OTP_W-DATA_W){1'b0}}};
  wire [OTP_W-1:0] rx_new = {rx_q[OTP_W-2:0], din_m};
  wire [31:0] stat_word = {30'h0, done_q, busy};
  wire [31:0] rd_mux = (addr_in == ADDR_CTRL) ? {27'h0, cmd_q} :
                       (addr_in == ADDR_WLO) ? wdat_q[31:0] :
                       (addr_in == ADDR_WHI) ? {18'h0, wdat_q[OTP_W-1:32]} :
                       (addr_in == ADDR_RLO) ? rdat_q[31:0] :
                       (addr_in == ADDR_RHI) ? {18'h0, rdat_q[OTP_W-1:32]} :
                       (addr_in == ADDR_STAT) ? stat_word : 32'h0;

  // Register port
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      wdat_q <= '0;
      rdata_out <= '0;
    end else begin
      if (wr_in && addr_in == ADDR_WLO) begin
        wdat_q[31:0] <= wdata_in;
      end
      if (wr_in && addr_in == ADDR_WHI) begin
        wdat_q[OTP_W-1:32] <= wdata_in[OTP_W-33:0];
      end
      rdata_out <= rd_in ? rd_mux : 32'h0;
    end
  end

  // Frame sequencer; the link clock is a divider of the internal clock
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= H_IDLE;
      tick_q <= '0;
      bit_q <= '0;
      tx_q <= '0;
      rx_q <= '0;
      rdat_q <= '0;
      cmd_q <= '0;
      done_q <= 1'b0;
      cs_q <= 1'b0;
      sclk_q <= 1'b0;
      hdata_q <= 1'b0;
      hoe_q <= 1'b0;
    end else begin
      tick_q <= (state_q == H_IDLE || half_end) ? 8'h00 : tick_q + 8'h01;
      // Completion wins over a clear in the same cycle
      if (wr_in && addr_in == ADDR_STAT && wdata_in[STAT_DONE]) begin
        done_q <= 1'b0;
      end
      case (state_q)
        H_IDLE: begin
          if (start) begin
            cmd_q <= cmd_new;
            tx_q <= tx_new;
            bit_q <= '0;
            cs_q <= 1'b1;
            state_q <= H_SETUP;
          end
        end
        H_SETUP: begin
          if (half_end) begin
            hdata_q <= tx_q[FRAME_W-1];
            hoe_q <= 1'b1;
            state_q <= H_LOW;
          end
        end
        H_LOW: begin
          if (half_end) begin
            sclk_q <= 1'b1;
            if (rd_cmd && in_data) begin
              rx_q <= rx_new;
            end
            state_q <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (tick_q == 8'h00 && rd_cmd && bit_q == CMD_LAST) begin
            hoe_q <= 1'b0;
          end
          if (half_end) begin
            sclk_q <= 1'b0;
            if (bit_q == last_bit) begin
              state_q <= H_HOLD;
            end else begin
              bit_q <= bit_q + 6'h01;
              tx_q <= {tx_q[FRAME_W-2:0], 1'b0};
              hdata_q <= tx_q[FRAME_W-2];
              state_q <= H_LOW;
            end
          end
        end
        H_HOLD: begin
          if (half_end) begin
            cs_q <= 1'b0;
            hoe_q <= 1'b0;
            rdat_q <= ext ? rx_q : {{(OTP_W-DATA_W){1'b0}}, rx_q[DATA_W-1:0]};
            done_q <= 1'b1;
            state_q <= H_IDLE;
          end
        end
        default: begin
          state_q <= H_IDLE;
        end
      endcase
    end
  end

  assign link.cs = cs_q;
  assign link.sclk = sclk_q;
  assign link.host_data = hdata_q;
  assign link.host_oe = hoe_q;
endmodule // rasp_host
`default_nettype wire

// ### rasp_link_sva.sv
// Concurrent checks on the serial link between the controller and sensor ends
`default_nettype none
module rasp_link_sva (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Link
  input wire logic cs,
  input wire logic sclk,
  input wire logic host_data,
  input wire logic host_oe,
  input wire logic dev_data,
  input wire logic dev_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sclk_q;
  logic [5:0] rise_q;
  logic [5:0] rise_d;
  logic [5:0] hi_q;
  logic [5:0] hi_d;
  // Rising link edges counted per frame; cleared while deselected
  assign rise_d = !cs ? 6'h00 : (sclk && !sclk_q) ? rise_q + 6'h01 : rise_q;
  assign hi_d = sclk ? hi_q + 6'h01 : 6'h00;
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      sclk_q <= 1'b0;
      rise_q <= 6'h00;
      hi_q <= 6'h00;
    end else begin
      sclk_q <= sclk;
      rise_q <= rise_d;
      hi_q <= hi_d;
    end
  end
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (reset_in);
  sequence s_turn;
    $fell(sclk) && rise_q == 6'h05;
  endsequence
  sequence s_last_fall;
    $fell(sclk) && (rise_q == 6'h15 || rise_q == 6'h33);
  endsequence
  property p_oe_excl;
    !(dev_oe && host_oe);
  endproperty
  property p_float;
    !cs |-> !dev_oe;
  endproperty
  property p_clk_idle;
    !cs |-> !sclk;
  endproperty
  property p_half;
    $fell(sclk) |-> hi_q == 6'h28;
  endproperty
  // Device takes the line only at the turnaround and keeps it for eight internal clock cycles at least
  property p_drive_start;
    $rose(dev_oe) |-> s_turn ##0 dev_oe [*8];
  endproperty
  property p_drive_end;
    $fell(dev_oe) && cs |-> s_last_fall;
  endproperty
  property p_frame_len;
    $fell(cs) |-> rise_q == 6'h15 || rise_q == 6'h33;
  endproperty
  property p_host_stable;
    host_oe && $past(host_oe) && $changed(host_data) |-> $fell(sclk);
  endproperty
  property p_dev_stable;
    dev_oe && $past(dev_oe) && $changed(dev_data) |-> $fell(sclk);
  endproperty
  a_oe_excl: assert property (p_oe_excl)
    else $error("both ends drive the data line");
  a_float: assert property (p_float)
    else $error("device drives while deselected");
  a_clk_idle: assert property (p_clk_idle)
    else $error("link clock runs outside a frame");
  a_half: assert property (p_half)
    else $error("link clock high phase has wrong length");
  a_drive_start: assert property (p_drive_start)
    else $error("device starts driving at the wrong edge");
  a_drive_end: assert property (p_drive_end)
    else $error("device releases the line at the wrong edge");
  a_frame_len: assert property (p_frame_len)
    else $error("frame has wrong bit count");
  a_host_stable: assert property (p_host_stable)
    else $error("controller data changes away from a falling edge");
  a_dev_stable: assert property (p_dev_stable)
    else $error("device data changes away from a falling edge");
endmodule // rasp_link_sva
`default_nettype wire

// ### tb_rotary_angle_serial_pwm_out.sv
// Self-checking bench: register port drives the controller, which talks to the sensor end
`default_nettype none
module tb_rotary_angle_serial_pwm_out;
  timeunit 1ns;
  timeprecision 1ps;
  import rasp_pkg::*;
  logic mclk_in, reset_in, wr_in, rd_in, rd_d1;
  logic [7:0] addr_in;
  logic [31:0] wdata_in, rdata_out, exp_w;
  logic [ANGLE_W-1:0] angle_in;
  logic [AGC_W-1:0] agc_in;
  logic lock_in, angle_valid_in, prog_voltage_ok_in, pwm_out, low_power_out;
  logic [GAIN_W-1:0] gain_out;
  logic [OTP_W-1:0] otp_data_out;
  logic [31:0] exp_q[$];
  int err_count, cmp_count;
  rasp_link_if u_link ();
  // Second link: bench plays a controller that stalls or deselects mid-frame
  rasp_link_if u_link_b ();
  rasp_host u_rasp_host (.mclk_in(mclk_in), .reset_in(reset_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .link(u_link.host));
  rasp_device u_rasp_device (.mclk_in(mclk_in), .reset_in(reset_in), .link(u_link.dev),
    .angle_in(angle_in), .agc_in(agc_in), .lock_in(lock_in), .angle_valid_in(angle_valid_in),
    .prog_voltage_ok_in(prog_voltage_ok_in), .pwm_out(pwm_out), .gain_out(gain_out),
    .low_power_out(low_power_out), .otp_data_out(otp_data_out));
  rasp_device u_rasp_device_b (.mclk_in(mclk_in), .reset_in(reset_in), .link(u_link_b.dev),
    .angle_in(angle_in), .agc_in(agc_in), .lock_in(lock_in), .angle_valid_in(angle_valid_in),
    .prog_voltage_ok_in(prog_voltage_ok_in), .pwm_out(), .gain_out(), .low_power_out(),
    .otp_data_out());
  rasp_link_sva u_rasp_link_sva (.mclk_in(mclk_in), .reset_in(reset_in), .cs(u_link.cs),
    .sclk(u_link.sclk), .host_data(u_link.host_data), .host_oe(u_link.host_oe),
    .dev_data(u_link.dev_data), .dev_oe(u_link.dev_oe));
  initial begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end
  task automatic test_done();
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [45:0] got, input logic [45:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    wr_in <= w;
    rd_in <= r;
    addr_in <= a;
    wdata_in <= d;
    @(posedge mclk_in);
  endtask
  task automatic idle(input int n);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    repeat (n) @(posedge mclk_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 32'h0);
  endtask
  // Read data stand one cycle after the strobe; the oldest note is compared then
  always @(posedge mclk_in) begin
    if (rd_d1 === 1'b1) begin
      cmp_count++;
      exp_w = exp_q.pop_front();
      if (rdata_out !== exp_w) begin
        err_count++;
        $display("MISMATCH %0t read got %h exp %h", $time, rdata_out, exp_w);
      end
    end
    rd_d1 <= rd_in;
  end
  task automatic frame(input logic [4:0] cmd, input logic [45:0] d);
    bus(1'b1, 1'b0, ADDR_WLO, d[31:0]);
    bus(1'b1, 1'b0, ADDR_WHI, {18'h0, d[45:32]});
    bus(1'b1, 1'b0, ADDR_CTRL, {27'h0, cmd});
    rd(ADDR_STAT, 32'h1);
    idle(cmd[3:0] == CMD_EXT_TAIL ? 4300 : 1800);
    rd(ADDR_STAT, 32'h2);
    bus(1'b1, 1'b0, ADDR_STAT, 32'h2);
    rd(ADDR_STAT, 32'h0);
    idle(1);
  endtask
  task automatic wait_lvl(input logic v);
    int n;
    n = 0;
    while (pwm_out !== v && n < 3000) begin
      @(posedge mclk_in);
      n++;
    end
    if (n >= 3000) begin
      err_count++;
      $display("MISMATCH %0t pwm output stuck", $time);
      test_done();
    end
  endtask
  task automatic pwm_chk(input logic [7:0] ang);
    int hi;
    int lo;
    angle_in <= ang;
    angle_valid_in <= 1'b1;
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    // Changing the angle mid-period must not disturb the running period
    angle_in <= ~ang;
    hi = 0;
    do begin hi++; @(posedge mclk_in); end while (pwm_out === 1'b1 && hi < 3000);
    lo = 0;
    do begin lo++; @(posedge mclk_in); end while (pwm_out === 1'b0 && lo < 3000);
    chk(46'(hi), 46'((int'(ang) + 1) * PWM_UNIT_CYC));
    chk(46'(lo), 46'((256 - int'(ang)) * PWM_UNIT_CYC));
  endtask
  task automatic l2_cmd(input logic [4:0] c);
    int i;
    // Link clock stands still while deselected; only frame edges restart the timeout
    #500 u_link_b.cs = 1'b1;
    #500;
    for (i = 4; i >= 0; i--) begin
      u_link_b.host_data = c[i];
      u_link_b.host_oe = 1'b1;
      #16 u_link_b.sclk = 1'b1;
      #8 u_link_b.host_oe = (i != 0);
      #8 u_link_b.sclk = 1'b0;
    end
    #5;
  endtask
  initial begin
    logic [15:0] w;
    logic [45:0] pat;
    int g;
    u_link_b.cs = 1'b0;
    u_link_b.sclk = 1'b0;
    u_link_b.host_data = 1'b0;
    u_link_b.host_oe = 1'b0;
    {reset_in, wr_in, rd_in, addr_in, wdata_in} = {3'h4, 40'h0};
    {angle_in, agc_in, lock_in, angle_valid_in, prog_voltage_ok_in} = 17'h0;
    err_count = 0;
    cmp_count = 0;
    void'($urandom(45045));
    repeat (4) @(posedge mclk_in);
    reset_in <= 1'b0;
    rd(ADDR_STAT, 32'h0);
    bus(1'b1, 1'b0, 8'h18, $urandom());
    rd(8'h18, 32'h0);
    rd(ADDR_RLO, 32'h0);
    chk(46'(gain_out), 46'(GAIN_RST));
    for (g = 1; g <= 8; g++) begin
      frame(CMD_WR_CUST, 46'(g % 8) << GAIN_LSB);
      chk(46'(gain_out), 46'(g % 8));
      if (g == 5) begin
        frame(CMD_RD_CUST, 46'h0);
        rd(ADDR_RLO, 32'h140);
      end
    end
    angle_valid_in <= 1'b1;
    for (g = 0; g < 3; g++) begin
      w[15:1] = {1'(g != 1), 6'($urandom()), 8'($urandom())};
      w[0] = ^w[15:1];
      lock_in <= w[15];
      agc_in <= w[14:9];
      angle_in <= w[8:1];
      frame(CMD_RD_ANGLE, 46'h0);
      rd(ADDR_RLO, {16'h0, w});
    end
    frame(CMD_WR_CONFIG, 46'h8000);
    chk(46'(low_power_out), 46'h1);
    w[15:1] = {1'b0, agc_in, angle_in};
    w[0] = ^w[15:1];
    frame(CMD_RD_ANGLE, 46'h0);
    rd(ADDR_RLO, {16'h0, w});
    frame(CMD_WR_CONFIG, 46'h0);
    chk(46'(low_power_out), 46'h0);
    pat = 46'({$urandom(), $urandom()});
    frame(CMD_WR_OTP, pat);
    chk(otp_data_out, 46'h0);
    prog_voltage_ok_in <= 1'b1;
    frame(CMD_WR_OTP, pat);
    chk(otp_data_out, pat);
    frame(CMD_RD_OTP, 46'h0);
    rd(ADDR_RLO, pat[31:0]);
    rd(ADDR_RHI, {18'h0, pat[45:32]});
    prog_voltage_ok_in <= 1'b0;
    idle(2);
    pwm_chk(8'h00);
    pwm_chk(8'hFF);
    pwm_chk(8'($urandom()));
    angle_valid_in <= 1'b0;
    repeat (5700) @(posedge mclk_in);
    g = 0;
    repeat (2827) begin
      @(posedge mclk_in);
      if (pwm_out !== 1'b0) g++;
    end
    chk(46'(g), 46'h0);
    angle_valid_in <= 1'b1;
    l2_cmd(CMD_RD_ANGLE);
    chk(46'(u_link_b.dev_oe), 46'h1);
    chk(46'(u_link_b.serial_data_io), 46'h1);
    #19000 chk(46'(u_link_b.dev_oe), 46'h1);
    #6000 chk(46'(u_link_b.dev_oe), 46'h0);
    u_link_b.cs = 1'b0;
    l2_cmd(CMD_RD_ANGLE);
    u_link_b.cs = 1'b0;
    #1 chk(46'(u_link_b.dev_oe), 46'h0);
    chk(46'(u_link_b.serial_data_io), 46'h1);
    @(posedge mclk_in);
    test_done();
  end
  initial begin
    repeat (100000) @(posedge mclk_in);
    err_count++;
    $display("MISMATCH %0t run did not finish", $time);
    test_done();
  end
endmodule // tb_rotary_angle_serial_pwm_out
`default_nettype wire
